// [rtl/plp_port_policer.sv]
// Per-port ingress policer with register port, verdicts and pause requests
`timescale 1ns/100ps

// How it works
// - Eight-bit class mask per policer chooses which traffic classes it polices.
// - One bit per policer counts frames instead of bytes.
// - MAC control, pause and short errored frames are neither policed nor charged.
// - A policer acts only with a selected class and a nonzero 17-bit rate.
// - Six-bit burst threshold, counted in 4K steps.
// - Mask bit 7 selects host-bound traffic; a queue mask exempts host queues.
// - Separate enables limit host-bound and front-bound frames of a closed policer.
// - Serial mode: first dropping policer stops charging of later policers.
// - Parallel mode: each policer charges if open, drops if closed.
// - Seven-bit signed gap adjustment added to each frame length.
// - Frames with precedence below the bypass level are not policed.
// - A closed dropping policer discards the whole frame, host copy included.
// - With pause mode a closed policer requests pause instead of dropping.
// - Six-bit hysteresis sets how far the fill must fall before reopening.
// - Each policer shows its current pause state in a readable bit.
// - Same hysteresis delays reopening in drop mode too.
// - Global bit selects logical instead of physical port as policer index.
// - Dropped frames raise a statistics event with the ingress port.
// - Sticky flags for pipeline bypass and precedence bypass.
// - Sticky flags for host-bound drops and front-bound drops.
// - Sticky flags for active-and-open, pause entry and pause exit.
module plp_port_policer (
	input logic clk,
	input logic resetn,
	input logic [7:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_we,
	input logic reg_re,
	output logic [31:0] reg_rdata,
	input plp_pkg::plp_frame_t frame_in,
	output plp_pkg::plp_verdict_t verdict,
	output plp_pkg::plp_stat_t stat_ev,
	output logic [plp_pkg::NPORT-1:0] pause_req
);

	plp_pkg::plp_cfg_t cfg_q [plp_pkg::NPOL];
	plp_pkg::plp_cfg_t cfg_d [plp_pkg::NPOL];
	logic [plp_pkg::RATE_W-1:0] rate_q [plp_pkg::NPOL];
	logic [plp_pkg::RATE_W-1:0] rate_d [plp_pkg::NPOL];
	logic [plp_pkg::THR_W-1:0] burst_q [plp_pkg::NPOL];
	logic [plp_pkg::THR_W-1:0] burst_d [plp_pkg::NPOL];
	logic [plp_pkg::THR_W-1:0] hyst_q [plp_pkg::NPOL];
	logic [plp_pkg::THR_W-1:0] hyst_d [plp_pkg::NPOL];
	logic [plp_pkg::NSTK-1:0] stk_q [plp_pkg::NPOL];
	logic [plp_pkg::NSTK-1:0] stk_d [plp_pkg::NPOL];
	logic [plp_pkg::NSTK-1:0] stk_set [plp_pkg::NPOL];
	logic [plp_pkg::FILL_W-1:0] charge_amt [plp_pkg::NPOL];
	logic [plp_pkg::NPOL-1:0] pause_prev_q, pause_prev_d;
	logic [plp_pkg::NPOL-1:0] pause_now, closed, charge;
	logic [plp_pkg::GLB_W-1:0] glb_q, glb_d;
	logic [31:0] rdata_q, rdata_d;
	plp_pkg::plp_verdict_t verdict_q, verdict_d;
	plp_pkg::plp_stat_t stat_q, stat_d;
	logic [plp_pkg::NPORT-1:0] pause_req_q, pause_req_d;
	logic [plp_pkg::TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic tick_q, tick_d;
	logic pol_hit;
	logic [plp_pkg::POL_W-1:0] pol_idx;
	logic [3:0] pol_ofs;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign pol_hit = reg_addr[plp_pkg::POL_SEL_BIT];
	assign pol_idx = reg_addr[plp_pkg::POL_SEL_BIT-1:plp_pkg::POL_IDX_LSB];
	assign pol_ofs = reg_addr[plp_pkg::POL_IDX_LSB-1:0];

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_comb begin
		glb_d = glb_q;
		if (reg_we && !pol_hit && reg_addr == plp_pkg::GLB_OFS) begin
			glb_d = reg_wdata[plp_pkg::GLB_W-1:0];
		end
		for (int p = 0; p < plp_pkg::NPOL; p++) begin
			cfg_d[p] = cfg_q[p];
			rate_d[p] = rate_q[p];
			burst_d[p] = burst_q[p];
			hyst_d[p] = hyst_q[p];
			if (reg_we && pol_hit && pol_idx == plp_pkg::POL_W'(p)) begin
				case (pol_ofs)
					plp_pkg::CFG_OFS: begin
						cfg_d[p] = plp_pkg::plp_cfg_t'(reg_wdata[plp_pkg::CFG_W-1:0]);
					end
					plp_pkg::RATE_OFS: begin
						rate_d[p] = reg_wdata[plp_pkg::RATE_W-1:0];
					end
					plp_pkg::THR_OFS: begin
						burst_d[p] = reg_wdata[plp_pkg::THR_BURST_LSB +: plp_pkg::THR_W];
						hyst_d[p] = reg_wdata[plp_pkg::THR_HYST_LSB +: plp_pkg::THR_W];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data, valid only in the cycle after the strobe
	// ----------------------------------------------------------------
	always_comb begin
		rdata_d = '0;
		if (reg_re) begin
			if (!pol_hit) begin
				if (reg_addr == plp_pkg::GLB_OFS) begin
					rdata_d = 32'(glb_q);
				end
			end else begin
				case (pol_ofs)
					plp_pkg::CFG_OFS: begin
						rdata_d = 32'(cfg_q[pol_idx]);
					end
					plp_pkg::RATE_OFS: begin
						rdata_d = 32'(rate_q[pol_idx]);
					end
					plp_pkg::THR_OFS: begin
						rdata_d[plp_pkg::THR_BURST_LSB +: plp_pkg::THR_W] = burst_q[pol_idx];
						rdata_d[plp_pkg::THR_HYST_LSB +: plp_pkg::THR_W] = hyst_q[pol_idx];
					end
					plp_pkg::STAT_OFS: begin
						rdata_d[plp_pkg::STAT_PAUSE_BIT] = pause_now[pol_idx];
						rdata_d[plp_pkg::STAT_STK_LSB +: plp_pkg::NSTK] = stk_q[pol_idx];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Drain tick, one pulse per microsecond
	// ----------------------------------------------------------------
	always_comb begin
		tick_d = (tick_cnt_q == plp_pkg::TICK_W'(plp_pkg::TICK_CYCLES - 1));
		tick_cnt_d = tick_d ? '0 : tick_cnt_q + 1'b1;
	end

	// ----------------------------------------------------------------
	// Buckets
	// ----------------------------------------------------------------
	for (genvar g = 0; g < plp_pkg::NPOL; g++) begin : g_bkt
		plp_bucket u_bkt (
			.clk(clk),
			.resetn(resetn),
			.tick(tick_q),
			.rate(rate_q[g]),
			.burst(burst_q[g]),
			.hyst(hyst_q[g]),
			.charge(charge[g]),
			.amount(charge_amt[g]),
			.closed(closed[g])
		);
		// closed pause-mode policer asks for pause
		assign pause_now[g] = closed[g] & cfg_q[g].pause_instead_of_drop;
	end

	// ----------------------------------------------------------------
	// Frame evaluation
	// ----------------------------------------------------------------
	always_comb begin
		logic elig;
		logic blocked;
		logic sel;
		logic byp_dp;
		logic act;
		logic eval;
		logic aff_h;
		logic aff_f;
		logic dropk;
		logic drop_any;
		logic [plp_pkg::PORT_W-1:0] idx;
		int amt;
		elig = 1'b0;
		blocked = 1'b0;
		sel = 1'b0;
		byp_dp = 1'b0;
		act = 1'b0;
		eval = 1'b0;
		aff_h = 1'b0;
		aff_f = 1'b0;
		dropk = 1'b0;
		drop_any = 1'b0;
		idx = '0;
		amt = 0;
		charge = '0;
		// only frames the MAC passes on
		elig = frame_in.valid && !frame_in.mac_ctrl
			&& !(frame_in.mac_err && frame_in.len < plp_pkg::SHORT_ERR_LEN);
		idx = glb_q[plp_pkg::GLB_LPORT_BIT] ? frame_in.lport : frame_in.port;
		for (int p = 0; p < plp_pkg::NPOL; p++) begin
			stk_set[p] = '0;
			// class selection, host class bit, rate configured
			sel = elig && (p / plp_pkg::NSUB == int'(idx)) && rate_q[p] != '0
				&& (cfg_q[p].class_mask[frame_in.tclass]
				|| (frame_in.to_host && cfg_q[p].class_mask[plp_pkg::HOST_CLASS_BIT]));
			byp_dp = frame_in.drop_precedence < cfg_q[p].precedence_bypass_level;
			act = sel && !frame_in.pipe_bypass && !byp_dp;
			stk_set[p][plp_pkg::STK_PIPE] = sel && frame_in.pipe_bypass;
			stk_set[p][plp_pkg::STK_DPB] = sel && !frame_in.pipe_bypass && byp_dp;
			aff_h = frame_in.to_host && cfg_q[p].limit_host_bound_traffic
				&& !cfg_q[p].host_queue_exempt_mask[frame_in.host_q];
			aff_f = frame_in.to_front && cfg_q[p].limit_front_port_traffic;
			// serial stops after a drop, parallel evaluates all
			eval = act && (glb_q[plp_pkg::GLB_PAR_BIT] || !blocked);
			charge[p] = eval && !closed[p];
			// closed drop-mode policer discards, pause mode never drops
			dropk = eval && closed[p] && !cfg_q[p].pause_instead_of_drop && (aff_h || aff_f);
			blocked = blocked | dropk;
			drop_any = drop_any | dropk;
			stk_set[p][plp_pkg::STK_HDROP] = dropk && aff_h;
			stk_set[p][plp_pkg::STK_FDROP] = dropk && aff_f;
			stk_set[p][plp_pkg::STK_ACT] = eval && !closed[p];
			stk_set[p][plp_pkg::STK_PIN] = pause_now[p] && !pause_prev_q[p];
			stk_set[p][plp_pkg::STK_POUT] = !pause_now[p] && pause_prev_q[p];
			// frame or byte charge, gap adjustment
			if (cfg_q[p].count_frames_not_bytes) begin
				amt = plp_pkg::FRAME_CHARGE;
			end else begin
				amt = int'(frame_in.len) + int'($signed(cfg_q[p].gap_adjust));
				if (amt < 0) begin
					amt = 0;
				end
			end
			charge_amt[p] = plp_pkg::FILL_W'(amt);
		end
		verdict_d.valid = frame_in.valid;
		verdict_d.drop = drop_any;
		verdict_d.port = frame_in.port;
		// statistics event on the ingress port
		stat_d.valid = drop_any;
		stat_d.port = frame_in.port;
	end

	// ----------------------------------------------------------------
	// Sticky flags and pause output
	// ----------------------------------------------------------------
	always_comb begin
		logic [plp_pkg::NSTK-1:0] clr;
		clr = '0;
		pause_req_d = '0;
		pause_prev_d = pause_now;
		for (int p = 0; p < plp_pkg::NPOL; p++) begin
			clr = '0;
			if (reg_we && pol_hit && pol_idx == plp_pkg::POL_W'(p)
				&& pol_ofs == plp_pkg::STAT_OFS) begin
				clr = reg_wdata[plp_pkg::STAT_STK_LSB +: plp_pkg::NSTK];
			end
			// write one clears, new event wins
			stk_d[p] = (stk_q[p] & ~clr) | stk_set[p];
			// global enable gates pause toward the MAC
			if (pause_now[p] && glb_q[plp_pkg::GLB_PAUSE_BIT]) begin
				pause_req_d[p / plp_pkg::NSUB] = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration state
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int p = 0; p < plp_pkg::NPOL; p++) begin
				cfg_q[p] <= plp_pkg::CFG_RST;
				rate_q[p] <= plp_pkg::RATE_RST;
				burst_q[p] <= plp_pkg::THR_RST;
				hyst_q[p] <= plp_pkg::THR_RST;
			end
			glb_q <= plp_pkg::GLB_RST;
		end else begin
			for (int p = 0; p < plp_pkg::NPOL; p++) begin
				cfg_q[p] <= cfg_d[p];
				rate_q[p] <= rate_d[p];
				burst_q[p] <= burst_d[p];
				hyst_q[p] <= hyst_d[p];
			end
			glb_q <= glb_d;
		end
	end

	// ----------------------------------------------------------------
	// Read data register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Drain tick divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end

	// ----------------------------------------------------------------
	// Verdict and statistics registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			verdict_q <= '0;
			stat_q <= '0;
		end else begin
			verdict_q <= verdict_d;
			stat_q <= stat_d;
		end
	end

	// ----------------------------------------------------------------
	// Sticky and pause registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int p = 0; p < plp_pkg::NPOL; p++) begin
				stk_q[p] <= '0;
			end
			pause_prev_q <= '0;
			pause_req_q <= '0;
		end else begin
			for (int p = 0; p < plp_pkg::NPOL; p++) begin
				stk_q[p] <= stk_d[p];
			end
			pause_prev_q <= pause_prev_d;
			pause_req_q <= pause_req_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_q;
	assign verdict = verdict_q;
	assign stat_ev = stat_q;
	assign pause_req = pause_req_q;

endmodule

// [include/plp_pkg.sv]
// Constants, register layout and carrier types of the port leaky bucket policer
package plp_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NPORT = 4;
	localparam int NSUB = 2;
	localparam int NPOL = NPORT * NSUB;
	localparam int PORT_W = 2;
	localparam int POL_W = 3;
	localparam int LEN_W = 14;
	localparam int RATE_W = 17;
	localparam int THR_W = 6;
	localparam int GAP_W = 7;
	localparam int FILL_W = 24;
	localparam int NSTK = 7;
	localparam int CFG_W = 29;
	localparam int GLB_W = 3;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] GLB_OFS = 8'h00;
	localparam int POL_SEL_BIT = 7;
	localparam int POL_IDX_LSB = 4;
	localparam logic [3:0] CFG_OFS = 4'h0;
	localparam logic [3:0] RATE_OFS = 4'h4;
	localparam logic [3:0] THR_OFS = 4'h8;
	localparam logic [3:0] STAT_OFS = 4'hc;
	localparam int THR_BURST_LSB = 0;
	localparam int THR_HYST_LSB = 8;
	localparam int STAT_PAUSE_BIT = 0;
	localparam int STAT_STK_LSB = 8;
	localparam int GLB_PAR_BIT = 0;
	localparam int GLB_PAUSE_BIT = 1;
	localparam int GLB_LPORT_BIT = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [CFG_W-1:0] CFG_RST = 29'h0;
	localparam logic [RATE_W-1:0] RATE_RST = 17'h0;
	localparam logic [THR_W-1:0] THR_RST = 6'h0;
	localparam logic [GLB_W-1:0] GLB_RST = 3'h0;

	// ----------------------------------------------------------------
	// Sticky flag positions
	// ----------------------------------------------------------------
	localparam int STK_PIPE = 0;
	localparam int STK_DPB = 1;
	localparam int STK_HDROP = 2;
	localparam int STK_FDROP = 3;
	localparam int STK_ACT = 4;
	localparam int STK_PIN = 5;
	localparam int STK_POUT = 6;

	// ----------------------------------------------------------------
	// Policing constants and timing
	// ----------------------------------------------------------------
	localparam int HOST_CLASS_BIT = 7;
	localparam logic [LEN_W-1:0] SHORT_ERR_LEN = 14'h0094;
	localparam int THR_UNIT_SH = 12;
	localparam int FRAME_CHARGE = 4096;
	localparam int CLK_MHZ = 100;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS * CLK_MHZ + 999) / 1000;
	localparam int TICK_W = 7;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [GAP_W-1:0] gap_adjust;
		logic [1:0] precedence_bypass_level;
		logic pause_instead_of_drop;
		logic limit_host_bound_traffic;
		logic limit_front_port_traffic;
		logic count_frames_not_bytes;
		logic [7:0] host_queue_exempt_mask;
		logic [7:0] class_mask;
	} plp_cfg_t;

	typedef struct packed {
		logic valid;
		logic [PORT_W-1:0] port;
		logic [PORT_W-1:0] lport;
		logic [LEN_W-1:0] len;
		logic [2:0] tclass;
		logic to_host;
		logic [2:0] host_q;
		logic to_front;
		logic [1:0] drop_precedence;
		logic pipe_bypass;
		logic mac_err;
		logic mac_ctrl;
	} plp_frame_t;

	typedef struct packed {
		logic valid;
		logic drop;
		logic [PORT_W-1:0] port;
	} plp_verdict_t;

	typedef struct packed {
		logic valid;
		logic [PORT_W-1:0] port;
	} plp_stat_t;

endpackage

// [rtl/plp_bucket.sv]
// One leaky bucket with burst threshold and reopen hysteresis
`timescale 1ns/100ps
module plp_bucket (
	input logic clk,
	input logic resetn,
	input logic tick,
	input logic [plp_pkg::RATE_W-1:0] rate,
	input logic [plp_pkg::THR_W-1:0] burst,
	input logic [plp_pkg::THR_W-1:0] hyst,
	input logic charge,
	input logic [plp_pkg::FILL_W-1:0] amount,
	output logic closed
);

	logic [plp_pkg::FILL_W-1:0] fill_q, fill_d, lim, hgt, low;
	logic [plp_pkg::FILL_W:0] sum;
	logic closed_q, closed_d;

	// ----------------------------------------------------------------
	// Fill and open state
	// ----------------------------------------------------------------
	always_comb begin
		lim = plp_pkg::FILL_W'(burst) << plp_pkg::THR_UNIT_SH;
		hgt = plp_pkg::FILL_W'(hyst) << plp_pkg::THR_UNIT_SH;
		low = (lim > hgt) ? lim - hgt : '0;
		fill_d = fill_q;
		if (tick) begin
			fill_d = (fill_q > plp_pkg::FILL_W'(rate)) ? fill_q - plp_pkg::FILL_W'(rate) : '0;
		end
		sum = {1'b0, fill_d} + {1'b0, amount};
		if (charge) begin
			fill_d = sum[plp_pkg::FILL_W] ? '1 : sum[plp_pkg::FILL_W-1:0];
		end
		closed_d = closed_q;
		if (!closed_q && fill_d > lim) begin
			closed_d = 1'b1;
		end else if (closed_q && fill_d <= low) begin
			closed_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			fill_q <= '0;
			closed_q <= 1'b0;
		end else begin
			fill_q <= fill_d;
			closed_q <= closed_d;
		end
	end

	assign closed = closed_q;

endmodule

// [test/plp_frame_src.sv]
// Frame pipeline model feeding descriptors into the policer
`timescale 1ns/100ps
module plp_frame_src (
	input logic clk,
	input logic send,
	input plp_pkg::plp_frame_t req,
	output plp_pkg::plp_frame_t frame_in
);
	localparam int FW = $bits(plp_pkg::plp_frame_t);
	initial frame_in = '0;
	// Idle cycles scramble the fields so that stale values are never trusted
	always @(posedge clk) begin
		if (send)
			frame_in <= {1'b1, req[FW-2:0]};
		else
			frame_in <= {1'b0, ~frame_in[FW-2:0]};
	end
endmodule

// [test/plp_port_policer_props.sv]
// Port assertions of the port leaky bucket policer
`timescale 1ns/100ps
module plp_props (
	input logic clk,
	input logic resetn,
	input logic [7:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_we,
	input logic reg_re,
	input logic [31:0] reg_rdata,
	input plp_pkg::plp_frame_t frame_in,
	input plp_pkg::plp_verdict_t verdict,
	input plp_pkg::plp_stat_t stat_ev,
	input logic [plp_pkg::NPORT-1:0] pause_req
);
	logic gp_q;
	logic gp_d;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// ----
	// Global pause enable
	// ----
	always_comb begin
		gp_d = gp_q;
		if (reg_we && reg_addr == plp_pkg::GLB_OFS)
			gp_d = reg_wdata[plp_pkg::GLB_PAUSE_BIT];
	end
	always_ff @(posedge clk) begin
		if (!resetn)
			gp_q <= 1'b0;
		else
			gp_q <= gp_d;
	end
	// ----
	// Properties
	// ----
	chk_verdict_follow: assert property (
		frame_in.valid |=> verdict.valid && verdict.port == $past(frame_in.port))
		else $error("verdict missing");
	chk_verdict_quiet: assert property (
		!frame_in.valid |=> !verdict.valid && !verdict.drop)
		else $error("verdict without frame");
	chk_stat_pairs: assert property (
		stat_ev.valid == (verdict.valid && verdict.drop))
		else $error("stat event mismatch");
	chk_stat_port: assert property (
		stat_ev.valid |-> stat_ev.port == verdict.port)
		else $error("stat port wrong");
	chk_ctrl_free: assert property (
		frame_in.valid && frame_in.mac_ctrl |=> !verdict.drop)
		else $error("control frame dropped");
	chk_short_err: assert property (
		frame_in.valid && frame_in.mac_err && frame_in.len < plp_pkg::SHORT_ERR_LEN
		|=> !verdict.drop)
		else $error("short errored frame dropped");
	chk_pipe_pass: assert property (
		frame_in.valid && frame_in.pipe_bypass |=> !verdict.drop)
		else $error("piped frame dropped");
	chk_rdata_idle: assert property (
		!$past(reg_re) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
	chk_pause_gate: assert property (
		|pause_req |-> gp_q || $past(gp_q))
		else $error("pause without global enable");
	cover property (stat_ev.valid);
	cover property (|pause_req);
	cover property (frame_in.valid && frame_in.mac_err);
endmodule

// [test/tb.sv]
// Self-checking bench of the port leaky bucket policer
`timescale 1ns/100ps
module tb;
	logic clk, resetn, reg_we, reg_re, send;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [15:0] lf;
	plp_pkg::plp_frame_t f, x, frame_in;
	plp_pkg::plp_verdict_t verdict;
	plp_pkg::plp_stat_t stat_ev;
	logic [plp_pkg::NPORT-1:0] pause_req;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;

	plp_port_policer plp_port_policer_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.frame_in(frame_in), .verdict(verdict), .stat_ev(stat_ev), .pause_req(pause_req));
	plp_frame_src plp_frame_src_i (.clk(clk), .send(send), .req(f), .frame_in(frame_in));

	// ----
	// Helpers
	// ----
	function automatic logic [15:0] nx(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [7:0] pa(logic [2:0] p, logic [3:0] o);
		return {1'b1, p, o};
	endfunction
	// Class 0 policed, frame counting, front limit always on
	function automatic logic [31:0] cfg(logic [7:0] ex, logic lh, logic pz, logic [1:0] lv);
		return {10'h0, lv, pz, lh, 2'b11, ex, 8'h01};
	endfunction
	function automatic plp_pkg::plp_frame_t fb(logic [1:0] p, logic [2:0] c);
		fb = '0;
		fb.port = p;
		fb.lport = p;
		fb.len = 14'h00c8;
		fb.tclass = c;
		fb.to_front = 1'b1;
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	task automatic chk(logic [7:0] a, logic [31:0] m, logic [31:0] e);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		#1;
		cmp("reg", e, reg_rdata & m);
	endtask
	task automatic pz(int n, logic [3:0] e);
		repeat (n) @(posedge clk);
		#1;
		cmp("pause", {28'h0, e}, {28'h0, pause_req});
	endtask
	task automatic snd(plp_pkg::plp_frame_t y, logic e);
		@(posedge clk);
		f <= y;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
		#1;
		cmp("vld", 32'h1, {31'h0, verdict.valid});
		cmp("drop", {31'h0, e}, {31'h0, verdict.drop});
		cmp("stat", {31'h0, e}, {31'h0, stat_ev.valid});
		if (e)
			cmp("port", {30'h0, y.port}, {30'h0, stat_ev.port});
	endtask
	// First policer closes on the first frame; second holds one frame
	task automatic chain(logic [31:0] g, logic [1:0] q, logic [1:0] pp, logic e);
		wr(8'h00, g);
		wr(pa({q, 1'b0}, 4'h0), cfg(8'h0, 1'b0, 1'b0, 2'h0));
		wr(pa({q, 1'b0}, 4'h4), 32'h1);
		wr(pa({q, 1'b0}, 4'h8), 32'h0);
		wr(pa({q, 1'b1}, 4'h0), cfg(8'h0, 1'b0, 1'b0, 2'h0));
		wr(pa({q, 1'b1}, 4'h4), 32'h1);
		wr(pa({q, 1'b1}, 4'h8), 32'h1);
		x = fb(pp, 3'h0);
		x.lport = q;
		snd(x, 1'b0);
		snd(x, 1'b1);
		wr(pa({q, 1'b0}, 4'h4), 32'h0);
		snd(x, e);
	endtask

	// ----
	// Clock, timeout and sequence
	// ----
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		resetn = 1'b0;
		reg_we = 1'b0;
		reg_re = 1'b0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		send = 1'b0;
		f = '0;
		lf = 16'h0060;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 32; i++)
			chk({1'b1, i[4:0], 2'b00}, 32'hffffffff, 32'h0);
		wr(8'h04, 32'hffffffff);
		chk(8'h04, 32'hffffffff, 32'h0);
		for (int i = 0; i < 8; i++) begin
			lf = nx(nx(lf));
			v = {lf, nx(lf)};
			wr(pa(i[2:0], 4'h0), v);
			wr(pa(i[2:0], 4'h4), v);
			wr(pa(i[2:0], 4'h8), v);
			chk(pa(i[2:0], 4'h0), 32'hffffffff, v & 32'h1fffffff);
			chk(pa(i[2:0], 4'h4), 32'hffffffff, v & 32'h0001ffff);
			chk(pa(i[2:0], 4'h8), 32'hffffffff, v & 32'h00003f3f);
			wr(pa(i[2:0], 4'h4), 32'h0);
		end
		wr(8'h00, 32'h7);
		chk(8'h00, 32'hffffffff, 32'h7);
		wr(8'h00, 32'h0);
		wr(pa(3'h0, 4'h0), cfg(8'h02, 1'b1, 1'b0, 2'h0));
		wr(pa(3'h0, 4'h4), 32'h1);
		wr(pa(3'h0, 4'h8), 32'h1);
		x = fb(2'h0, 3'h0);
		snd(x, 1'b0);
		snd(x, 1'b0);
		snd(x, 1'b1);
		x.tclass = 3'h1;
		snd(x, 1'b0);
		x.tclass = 3'h0;
		x.mac_ctrl = 1'b1;
		snd(x, 1'b0);
		x.mac_ctrl = 1'b0;
		x.mac_err = 1'b1;
		x.len = 14'h0093;
		snd(x, 1'b0);
		x.len = 14'h0094;
		snd(x, 1'b1);
		x.mac_err = 1'b0;
		x.to_front = 1'b0;
		x.to_host = 1'b1;
		x.host_q = 3'h1;
		snd(x, 1'b0);
		x.host_q = 3'h2;
		snd(x, 1'b1);
		wr(pa(3'h0, 4'h0), cfg(8'h02, 1'b0, 1'b0, 2'h0));
		snd(x, 1'b0);
		wr(pa(3'h0, 4'h0), cfg(8'h02, 1'b1, 1'b0, 2'h2));
		x = fb(2'h0, 3'h0);
		x.drop_precedence = 2'h1;
		snd(x, 1'b0);
		x.drop_precedence = 2'h2;
		snd(x, 1'b1);
		x.pipe_bypass = 1'b1;
		snd(x, 1'b0);
		chk(pa(3'h0, 4'hc), 32'h00007f01, 32'h00001f00);
		wr(pa(3'h0, 4'hc), 32'h00000800);
		chk(pa(3'h0, 4'hc), 32'h00007f01, 32'h00001700);
		wr(pa(3'h0, 4'h0), cfg(8'h02, 1'b1, 1'b1, 2'h0));
		pz(3, 4'h0);
		chk(pa(3'h0, 4'hc), 32'h00000001, 32'h1);
		snd(fb(2'h0, 3'h0), 1'b0);
		wr(8'h00, 32'h2);
		pz(3, 4'h1);
		chk(pa(3'h0, 4'hc), 32'h00002000, 32'h00002000);
		wr(pa(3'h0, 4'h8), 32'h0101);
		wr(pa(3'h0, 4'h4), 32'h1000);
		pz(60, 4'h1);
		pz(200, 4'h0);
		chk(pa(3'h0, 4'hc), 32'h00004001, 32'h00004000);
		for (int i = 0; i < 16; i++) begin
			lf = nx(lf);
			x = fb(2'h3, lf[2:0]);
			x.len = lf[15:2];
			x.to_host = lf[3];
			x.drop_precedence = lf[5:4];
			snd(x, 1'b0);
		end
		// Byte counting with a gap of minus eight on port 3
		wr(pa(3'h6, 4'h0), 32'h1e020001);
		wr(pa(3'h6, 4'h4), 32'h1);
		wr(pa(3'h6, 4'h8), 32'h1);
		x = fb(2'h3, 3'h0);
		x.len = 14'h0808;
		snd(x, 1'b0);
		snd(x, 1'b0);
		snd(x, 1'b0);
		snd(x, 1'b1);
		wr(pa(3'h6, 4'h8), 32'h0101);
		wr(pa(3'h6, 4'h4), 32'h0400);
		repeat (250) @(posedge clk);
		snd(x, 1'b1);
		chain(32'h0, 2'h1, 2'h1, 1'b0);
		chain(32'h5, 2'h2, 2'h0, 1'b1);
		final_report();
	end
endmodule

bind plp_port_policer plp_props plp_props_i (.clk(clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
	.reg_rdata(reg_rdata), .frame_in(frame_in), .verdict(verdict), .stat_ev(stat_ev),
	.pause_req(pause_req));
